// ===== common/optc_pkg.sv
// Purpose: constants and types for the output, power and timing control registers
// Assumes: byte-wide register port, offsets as printed
// Notes: nothing here is imported; users write optc_pkg::name

package optc_pkg;

	// ********************************************
	// register offsets
	// ********************************************
	localparam logic [7:0] ADDR_OUT_EN = 8'h25;
	localparam logic [7:0] ADDR_TRI_PD = 8'h26;
	localparam logic [7:0] ADDR_AUTO = 8'h27;
	localparam logic [7:0] ADDR_VDH = 8'h28;
	localparam logic [7:0] ADDR_HDL = 8'h29;
	localparam logic [7:0] ADDR_LWH = 8'h2a;
	localparam logic [7:0] ADDR_LWL = 8'h2b;
	localparam logic [7:0] ADDR_SHH = 8'h2c;
	localparam logic [7:0] ADDR_SHL = 8'h2d;
	localparam logic [7:0] ADDR_AUD = 8'h2e;
	localparam logic [7:0] ADDR_STATUS = 8'h2f;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// ********************************************
	// field positions
	// ********************************************
	localparam int SEC_EN_BIT = 0;
	localparam int PRI_EN_BIT = 1;
	localparam int MODE_LSB = 2;
	localparam int MODE_MSB = 3;
	localparam logic [1:0] MODE_422 = 2'h1;
	localparam logic [1:0] MODE_DDR444 = 2'h2;

	localparam int TRI_ALL_BIT = 7;
	localparam int TRI_SOG_BIT = 6;
	localparam int TRI_SPDIF_BIT = 5;
	localparam int TRI_I2S_BIT = 4;
	localparam int PD_POL_BIT = 3;
	localparam int PD_KEEP_UP_BIT = 2;
	localparam int PD_SOG_TRI_BIT = 1;
	localparam int PD_BIT = 0;

	localparam int AUTO_PD_BIT = 7;
	localparam int CP_ADDR_BIT = 6;
	localparam int MCLK_EXT_BIT = 5;
	localparam int EMB_SYNC_BIT = 4;
	localparam int DE_GEN_BIT = 3;
	localparam int ILACE_MSB = 2;
	localparam int ILACE_LSB = 0;

	localparam int VDLY_MSB = 7;
	localparam int VDLY_LSB = 2;
	localparam int HDLY_HI_MSB = 1;
	localparam int NIB_MSB = 3;

	localparam int CTRL_EN_BIT = 7;
	localparam int AFMT_MSB = 6;
	localparam int AFMT_LSB = 5;
	localparam int AWID_MSB = 4;

	localparam int ST_DE_BIT = 6;
	localparam int ST_CLK_BIT = 5;
	localparam int ST_MUTE_BIT = 4;

	// ********************************************
	// reset values
	// ********************************************
	localparam logic [7:0] RST_OUT_EN = 8'h72;
	localparam logic [7:0] RST_TRI_PD = 8'h08;
	localparam logic [7:0] RST_AUTO = 8'h80;
	localparam logic [7:0] RST_VDH = 8'h61;
	localparam logic [7:0] RST_HDL = 8'h04;
	localparam logic [3:0] RST_LWH = 4'h5;
	localparam logic [7:0] RST_LWL = 8'h00;
	localparam logic [3:0] RST_SHH = 4'h2;
	localparam logic [7:0] RST_SHL = 8'hd0;
	localparam logic [7:0] RST_AUD = 8'h18;

	// ********************************************
	// types
	// ********************************************
	typedef enum logic [1:0]
	{
		AFMT_I2S = 2'h0,
		AFMT_RIGHT = 2'h1,
		AFMT_LEFT = 2'h2,
		AFMT_RAW = 2'h3
	} optc_audio_fmt_t;

	typedef struct packed
	{
		logic [2:0] interlace_offset;
		logic [5:0] vsync_delay;
		logic [9:0] hsync_delay;
		logic [11:0] line_width;
		logic [11:0] screen_height;
	} optc_timing_t;

	localparam optc_timing_t TIMING_RST = '{3'h0, 6'h18, 10'h104, 12'h500, 12'h2d0};

	typedef struct packed
	{
		logic de_present;
		logic clk_present;
		logic av_mute;
	} optc_link_status_t;

	typedef struct packed
	{
		logic primary;
		logic secondary;
		logic sync;
		logic green_sync;
		logic spdif;
		logic i2s;
	} optc_pin_oe_t;

endpackage

// ===== hdl/optc_regs.sv
// Purpose: output enables, power-down, generated timing and audio format control
// Assumes: register port already decoded from the serial interface; inputs synchronous
// Notes: timing fields reach the generator only at frame start
// Functional notes
// (RULE1) blue carries secondary output in 4:2:2 or DDR 4:4:4; bit enables, default off
// (RULE2) secondary output is always formatted as DDR luma/chroma
// (RULE3) master tristate bit floats all outputs except green sync pin
// (RULE4) separate tristate bits for green sync, coaxial audio and serial audio pins
// (RULE5) polarity bit picks active level of power-down pin, default active high
// (RULE6) pin function field chooses power-down or not, and green sync tristate or not
// (RULE7) power-down bit floats syncs, data clock and data; green sync keeps driving
// (RULE8) register interface stays usable while powered down
// (RULE9) auto power-down when no sync present, enabled by default
// (RULE10) address lsb for content-protection slave; host sets only on second receiver
// (RULE11) external audio master clock select; host must lock it to video clock
// (RULE12) enable insertion of start and end of active video markers
// (RULE13) enable internal display-enable generator from programmed timing
// (RULE14) interlace field offset in horizontal syncs, default zero
// (RULE15) vertical delay in lines, default 24
// (RULE16) 10-bit horizontal delay in pixels split over two registers, default 0x104
// (RULE17) 12-bit active line width, default 0x500
// (RULE18) 12-bit active screen height, default 0x2d0
// (RULE19) control enable puts four link control signals on audio serial pins
// (RULE20) audio serial format select: I2S, right, left, raw frames
// (RULE21) right-justified sample width, default 24
// (RULE22) read-only status: display enable, link clock, mute
// (RULE23) primary output enable on red and green, default on
// (RULE24) split timing fields take effect together at frame start

`timescale 1ns/1ps

module optc_regs
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// power and sync inputs
	input wire logic power_down_input_i,
	input wire logic sync_present_i,
	input wire logic frame_start_i,
	input wire optc_pkg::optc_link_status_t link_status_i,
	// audio serial data sources
	input wire logic [3:0] audio_data_i,
	input wire logic [3:0] link_ctrl_i,
	// pin enables and power state
	output optc_pkg::optc_pin_oe_t pin_oe_o,
	output logic powered_down_o,
	output logic blue_carries_secondary_o,
	output logic secondary_ddr_ycc_o,
	// mode controls
	output logic cp_addr_lsb_o,
	output logic mclk_ext_sel_o,
	output logic embedded_sync_en_o,
	output logic de_gen_en_o,
	output optc_pkg::optc_timing_t timing_o,
	// audio serial controls
	output logic [3:0] audio_serial_o,
	output optc_pkg::optc_audio_fmt_t audio_fmt_o,
	output logic [4:0] audio_width_o
);

	// ********************************************
	// registers
	// ********************************************
	logic [7:0] out_en_q;
	logic [7:0] tri_pd_q;
	logic [7:0] auto_q;
	logic [7:0] vdh_q;
	logic [7:0] hdl_q;
	logic [3:0] lwh_q;
	logic [7:0] lwl_q;
	logic [3:0] shh_q;
	logic [7:0] shl_q;
	logic [7:0] aud_q;
	logic [7:0] rdata_q;
	optc_pkg::optc_timing_t timing_q;
	optc_pkg::optc_pin_oe_t oe_q;
	optc_pkg::optc_pin_oe_t oe_d;
	logic pd_q;
	logic [3:0] serial_q;
	logic [3:0] serial_d;

	// ********************************************
	// address decode
	// ********************************************
	logic wr_out_en;
	logic wr_tri_pd;
	logic wr_auto;
	logic wr_vdh;
	logic wr_hdl;
	logic wr_lwh;
	logic wr_lwl;
	logic wr_shh;
	logic wr_shl;
	logic wr_aud;
	logic [7:0] status_byte;
	logic [7:0] rd_mux;

	assign wr_out_en = reg_wr_i && (reg_addr_i == optc_pkg::ADDR_OUT_EN);
	assign wr_tri_pd = reg_wr_i && (reg_addr_i == optc_pkg::ADDR_TRI_PD);
	assign wr_auto = reg_wr_i && (reg_addr_i == optc_pkg::ADDR_AUTO);
	assign wr_vdh = reg_wr_i && (reg_addr_i == optc_pkg::ADDR_VDH);
	assign wr_hdl = reg_wr_i && (reg_addr_i == optc_pkg::ADDR_HDL);
	assign wr_lwh = reg_wr_i && (reg_addr_i == optc_pkg::ADDR_LWH);
	assign wr_lwl = reg_wr_i && (reg_addr_i == optc_pkg::ADDR_LWL);
	assign wr_shh = reg_wr_i && (reg_addr_i == optc_pkg::ADDR_SHH);
	assign wr_shl = reg_wr_i && (reg_addr_i == optc_pkg::ADDR_SHL);
	assign wr_aud = reg_wr_i && (reg_addr_i == optc_pkg::ADDR_AUD);

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[optc_pkg::ST_DE_BIT] = link_status_i.de_present; // RULE22
		status_byte[optc_pkg::ST_CLK_BIT] = link_status_i.clk_present; // RULE22
		status_byte[optc_pkg::ST_MUTE_BIT] = link_status_i.av_mute; // RULE22
	end

	assign rd_mux = (reg_addr_i == optc_pkg::ADDR_OUT_EN) ? out_en_q :
		(reg_addr_i == optc_pkg::ADDR_TRI_PD) ? tri_pd_q :
		(reg_addr_i == optc_pkg::ADDR_AUTO) ? auto_q :
		(reg_addr_i == optc_pkg::ADDR_VDH) ? vdh_q :
		(reg_addr_i == optc_pkg::ADDR_HDL) ? hdl_q :
		(reg_addr_i == optc_pkg::ADDR_LWH) ? {4'h0, lwh_q} :
		(reg_addr_i == optc_pkg::ADDR_LWL) ? lwl_q :
		(reg_addr_i == optc_pkg::ADDR_SHH) ? {4'h0, shh_q} :
		(reg_addr_i == optc_pkg::ADDR_SHL) ? shl_q :
		(reg_addr_i == optc_pkg::ADDR_AUD) ? aud_q :
		(reg_addr_i == optc_pkg::ADDR_STATUS) ? status_byte :
		optc_pkg::RD_UNMAPPED;

	// ********************************************
	// register writes and reads
	// ********************************************
	// writes and reads ignore power state
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			out_en_q <= optc_pkg::RST_OUT_EN;
			tri_pd_q <= optc_pkg::RST_TRI_PD;
			auto_q <= optc_pkg::RST_AUTO;
			aud_q <= optc_pkg::RST_AUD;
			rdata_q <= optc_pkg::RD_UNMAPPED;
		end
		else
		begin
			if (wr_out_en)
				out_en_q <= reg_wdata_i; // RULE1
			if (wr_tri_pd)
				tri_pd_q <= reg_wdata_i; // RULE8
			if (wr_auto)
				auto_q <= reg_wdata_i;
			if (wr_aud)
				aud_q <= reg_wdata_i;
			if (reg_rd_i)
				rdata_q <= rd_mux; // RULE8
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			vdh_q <= optc_pkg::RST_VDH;
			hdl_q <= optc_pkg::RST_HDL;
			lwh_q <= optc_pkg::RST_LWH;
			lwl_q <= optc_pkg::RST_LWL;
			shh_q <= optc_pkg::RST_SHH;
			shl_q <= optc_pkg::RST_SHL;
		end
		else
		begin
			if (wr_vdh)
				vdh_q <= reg_wdata_i;
			if (wr_hdl)
				hdl_q <= reg_wdata_i;
			if (wr_lwh)
				lwh_q <= reg_wdata_i[optc_pkg::NIB_MSB:0];
			if (wr_lwl)
				lwl_q <= reg_wdata_i;
			if (wr_shh)
				shh_q <= reg_wdata_i[optc_pkg::NIB_MSB:0];
			if (wr_shl)
				shl_q <= reg_wdata_i;
		end
	end

	// ********************************************
	// generated timing, applied at frame start
	// ********************************************
	optc_pkg::optc_timing_t timing_stage;

	assign timing_stage.interlace_offset = auto_q[optc_pkg::ILACE_MSB:optc_pkg::ILACE_LSB]; // RULE14
	assign timing_stage.vsync_delay = vdh_q[optc_pkg::VDLY_MSB:optc_pkg::VDLY_LSB]; // RULE15
	assign timing_stage.hsync_delay = {vdh_q[optc_pkg::HDLY_HI_MSB:0], hdl_q}; // RULE16
	assign timing_stage.line_width = {lwh_q, lwl_q}; // RULE17
	assign timing_stage.screen_height = {shh_q, shl_q}; // RULE18

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			timing_q <= optc_pkg::TIMING_RST;
		else if (frame_start_i)
			timing_q <= timing_stage; // RULE24
	end

	// ********************************************
	// power-down and output enables
	// ********************************************
	logic pd_pin_active;
	logic pin_down;
	logic auto_down;
	logic pd_d;
	logic tri_main;
	logic tri_sog;

	assign pd_pin_active = (power_down_input_i == tri_pd_q[optc_pkg::PD_POL_BIT]); // RULE5
	assign pin_down = pd_pin_active && !tri_pd_q[optc_pkg::PD_KEEP_UP_BIT]; // RULE6
	assign auto_down = auto_q[optc_pkg::AUTO_PD_BIT] && !sync_present_i; // RULE9
	assign pd_d = tri_pd_q[optc_pkg::PD_BIT] || pin_down || auto_down; // RULE7
	assign tri_main = tri_pd_q[optc_pkg::TRI_ALL_BIT] || pd_d || pd_pin_active; // RULE3 RULE6 RULE7
	assign tri_sog = tri_pd_q[optc_pkg::TRI_SOG_BIT] || (pd_pin_active && tri_pd_q[optc_pkg::PD_SOG_TRI_BIT]); // RULE4 RULE6

	assign oe_d.primary = out_en_q[optc_pkg::PRI_EN_BIT] && !tri_main; // RULE23
	assign oe_d.secondary = out_en_q[optc_pkg::SEC_EN_BIT] && !tri_main; // RULE1
	assign oe_d.sync = !tri_main; // RULE7
	assign oe_d.green_sync = !tri_sog; // RULE7
	assign oe_d.spdif = !tri_pd_q[optc_pkg::TRI_SPDIF_BIT] && !tri_main; // RULE4
	assign oe_d.i2s = !tri_pd_q[optc_pkg::TRI_I2S_BIT] && !tri_main; // RULE4

	assign serial_d = aud_q[optc_pkg::CTRL_EN_BIT] ? link_ctrl_i : audio_data_i; // RULE19

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			oe_q <= '0;
			pd_q <= 1'b0;
			serial_q <= 4'h0;
		end
		else
		begin
			oe_q <= oe_d;
			pd_q <= pd_d;
			serial_q <= serial_d;
		end
	end

	// ********************************************
	// outputs
	// ********************************************
	assign reg_rdata_o = rdata_q;
	assign pin_oe_o = oe_q;
	assign powered_down_o = pd_q;
	assign blue_carries_secondary_o = (out_en_q[optc_pkg::MODE_MSB:optc_pkg::MODE_LSB] == optc_pkg::MODE_422) ||
		(out_en_q[optc_pkg::MODE_MSB:optc_pkg::MODE_LSB] == optc_pkg::MODE_DDR444); // RULE1
	assign secondary_ddr_ycc_o = 1'b1; // RULE2
	assign cp_addr_lsb_o = auto_q[optc_pkg::CP_ADDR_BIT]; // RULE10
	assign mclk_ext_sel_o = auto_q[optc_pkg::MCLK_EXT_BIT]; // RULE11
	assign embedded_sync_en_o = auto_q[optc_pkg::EMB_SYNC_BIT]; // RULE12
	assign de_gen_en_o = auto_q[optc_pkg::DE_GEN_BIT]; // RULE13
	assign timing_o = timing_q;
	assign audio_serial_o = serial_q;
	assign audio_fmt_o = optc_pkg::optc_audio_fmt_t'(aud_q[optc_pkg::AFMT_MSB:optc_pkg::AFMT_LSB]); // RULE20
	assign audio_width_o = aud_q[optc_pkg::AWID_MSB:0]; // RULE21

	// ********************************************
	// assertions
	// ********************************************
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_wr_aud;
		reg_wr_i && (reg_addr_i == optc_pkg::ADDR_AUD) && tri_pd_q[optc_pkg::PD_BIT];
	endsequence
	sequence s_rd_aud;
		reg_rd_i && !reg_wr_i && (reg_addr_i == optc_pkg::ADDR_AUD);
	endsequence

	property p_sec_off;
		!out_en_q[optc_pkg::SEC_EN_BIT] |=> !pin_oe_o.secondary;
	endproperty
	a_sec_off: assert property (p_sec_off) else $error("secondary drives while disabled"); // RULE1

	property p_all_tri;
		tri_pd_q[optc_pkg::TRI_ALL_BIT] |=> !pin_oe_o.primary && !pin_oe_o.secondary && !pin_oe_o.sync
			&& !pin_oe_o.spdif && !pin_oe_o.i2s;
	endproperty
	a_all_tri: assert property (p_all_tri) else $error("output drives under master tristate"); // RULE3

	property p_sog_tri;
		tri_pd_q[optc_pkg::TRI_SOG_BIT] |=> !pin_oe_o.green_sync;
	endproperty
	a_sog_tri: assert property (p_sog_tri) else $error("green sync drives while tristated"); // RULE4

	property p_pin_all_tri;
		(power_down_input_i == tri_pd_q[optc_pkg::PD_POL_BIT]) && tri_pd_q[optc_pkg::PD_SOG_TRI_BIT]
			&& !tri_pd_q[optc_pkg::PD_KEEP_UP_BIT] |=> !pin_oe_o.green_sync && !pin_oe_o.sync && powered_down_o;
	endproperty
	a_pin_all_tri: assert property (p_pin_all_tri) else $error("pin power-down mode 01 not honoured"); // RULE5

	property p_pin_keep_up;
		(power_down_input_i != tri_pd_q[optc_pkg::PD_POL_BIT]) && !tri_pd_q[optc_pkg::PD_BIT] && sync_present_i
			|=> !powered_down_o;
	endproperty
	a_pin_keep_up: assert property (p_pin_keep_up) else $error("powered down without cause"); // RULE6

	property p_pd_bit;
		tri_pd_q[optc_pkg::PD_BIT] && !tri_pd_q[optc_pkg::TRI_SOG_BIT]
			&& (power_down_input_i != tri_pd_q[optc_pkg::PD_POL_BIT])
			|=> powered_down_o && !pin_oe_o.sync && pin_oe_o.green_sync;
	endproperty
	a_pd_bit: assert property (p_pd_bit) else $error("power-down bit pin states wrong"); // RULE7

	property p_reg_in_pd;
		s_wr_aud ##1 !reg_wr_i ##1 s_rd_aud |=> reg_rdata_o == $past(reg_wdata_i, 3);
	endproperty
	a_reg_in_pd: assert property (p_reg_in_pd) else $error("register lost during power-down"); // RULE8

	property p_auto;
		auto_q[optc_pkg::AUTO_PD_BIT] && !sync_present_i |=> powered_down_o;
	endproperty
	a_auto: assert property (p_auto) else $error("no auto power-down without sync"); // RULE9

	property p_ctrl_mux;
		aud_q[optc_pkg::CTRL_EN_BIT] |=> audio_serial_o == $past(link_ctrl_i);
	endproperty
	a_ctrl_mux: assert property (p_ctrl_mux) else $error("link control not on audio pins"); // RULE19

	property p_status;
		reg_rd_i && (reg_addr_i == optc_pkg::ADDR_STATUS)
			|=> reg_rdata_o[optc_pkg::ST_DE_BIT:optc_pkg::ST_MUTE_BIT] == $past(link_status_i);
	endproperty
	a_status: assert property (p_status) else $error("status read mismatch"); // RULE22

	property p_timing_hold;
		!frame_start_i |=> $stable(timing_o);
	endproperty
	a_timing_hold: assert property (p_timing_hold) else $error("timing changed outside frame start"); // RULE24

	property p_timing_load;
		frame_start_i |=> timing_o == $past(timing_stage);
	endproperty
	a_timing_load: assert property (p_timing_load) else $error("timing not loaded at frame start"); // RULE24

	property p_pri_off;
		!out_en_q[optc_pkg::PRI_EN_BIT] |=> !pin_oe_o.primary;
	endproperty
	a_pri_off: assert property (p_pri_off) else $error("primary drives while disabled"); // RULE23

	property p_spdif_tri;
		tri_pd_q[optc_pkg::TRI_SPDIF_BIT] |=> !pin_oe_o.spdif;
	endproperty
	a_spdif_tri: assert property (p_spdif_tri) else $error("coaxial audio drives while tristated"); // RULE4

	property p_i2s_tri;
		tri_pd_q[optc_pkg::TRI_I2S_BIT] |=> !pin_oe_o.i2s;
	endproperty
	a_i2s_tri: assert property (p_i2s_tri) else $error("serial audio drives while tristated"); // RULE4

	property p_pin_sog_keep;
		(power_down_input_i == tri_pd_q[optc_pkg::PD_POL_BIT]) && !tri_pd_q[optc_pkg::PD_SOG_TRI_BIT]
			&& !tri_pd_q[optc_pkg::TRI_SOG_BIT] |=> pin_oe_o.green_sync && !pin_oe_o.primary && !pin_oe_o.sync;
	endproperty
	a_pin_sog_keep: assert property (p_pin_sog_keep) else $error("pin mode green sync state wrong"); // RULE6

	property p_pin_stay_up;
		(power_down_input_i == tri_pd_q[optc_pkg::PD_POL_BIT]) && tri_pd_q[optc_pkg::PD_KEEP_UP_BIT]
			&& !tri_pd_q[optc_pkg::PD_BIT] && sync_present_i |=> !powered_down_o && !pin_oe_o.sync;
	endproperty
	a_pin_stay_up: assert property (p_pin_stay_up) else $error("pin mode stay powered not honoured"); // RULE6

	property p_audio_pass;
		!aud_q[optc_pkg::CTRL_EN_BIT] |=> audio_serial_o == $past(audio_data_i);
	endproperty
	a_audio_pass: assert property (p_audio_pass) else $error("audio data not on audio pins"); // RULE19

endmodule

// ===== verif/optc_host.sv
// Purpose: host model that programs the register port with one-cycle strobes
// Assumes: strobes taken on the rising edge, read data valid one cycle later
// Notes: released address and data lines carry the inverse of their last value
`timescale 1ns/1ps

module optc_host
#(
	parameter logic SECOND_RX = 1'b1,
	parameter logic MCLK_LOCKED = 1'b1
)
(
	// clock
	input wire logic sys_clk_i,
	// register port
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);
	// ********************************************
	// idle state
	// ********************************************
	initial
	begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end

	// ********************************************
	// bus cycles
	// ********************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
	begin
		v = d;
		if (a == optc_pkg::ADDR_AUTO && !SECOND_RX)
			v[optc_pkg::CP_ADDR_BIT] = 1'b0;
		if (a == optc_pkg::ADDR_AUTO && !MCLK_LOCKED)
			v[optc_pkg::MCLK_EXT_BIT] = 1'b0;
		@(negedge sys_clk_i);
		reg_addr_o = a;
		reg_wdata_o = v;
		reg_wr_o = 1'b1;
		@(negedge sys_clk_i);
		reg_wr_o = 1'b0;
		reg_addr_o = ~reg_addr_o;
		reg_wdata_o = ~reg_wdata_o;
	end
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
	begin
		@(negedge sys_clk_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge sys_clk_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~reg_addr_o;
		d = reg_rdata_i;
	end
	endtask
endmodule

// ===== verif/output_power_timing_control_tb.sv
// Purpose: self-checking bench for the output, power and timing control registers
// Assumes: inputs change on the falling edge, outputs one cycle after cause
// Notes: expected values are written out from the field definitions
`timescale 1ns/1ps

module output_power_timing_control_tb;
	logic sys_clk, rst_n, wr, rd, pdi, sp, fs, blue, ddr, pd_o, cp, mc, emb, de;
	logic [7:0] addr, wdata, rdata, rv;
	logic [3:0] ad, lc, aser;
	logic [4:0] awid;
	optc_pkg::optc_link_status_t ls;
	optc_pkg::optc_pin_oe_t oe;
	optc_pkg::optc_timing_t tim;
	optc_pkg::optc_audio_fmt_t afmt;
	int n_fail = 0;
	int samples_checked = 0;
	int i;
	logic [7:0] rst_tab [10] = '{optc_pkg::RST_OUT_EN, 8'h08, 8'h80, 8'h61, 8'h04, 8'h05, 8'h00, 8'h02, 8'hd0, 8'h18};
	logic [5:0] tri_tab [4] = '{6'b000100, 6'b101011, 6'b101101, 6'b101110};

	// ********************************************
	// design and host
	// ********************************************
	optc_regs i_optc_regs (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .power_down_input_i(pdi),
		.sync_present_i(sp), .frame_start_i(fs), .link_status_i(ls), .audio_data_i(ad), .link_ctrl_i(lc),
		.pin_oe_o(oe), .powered_down_o(pd_o), .blue_carries_secondary_o(blue), .secondary_ddr_ycc_o(ddr),
		.cp_addr_lsb_o(cp), .mclk_ext_sel_o(mc), .embedded_sync_en_o(emb), .de_gen_en_o(de),
		.timing_o(tim), .audio_serial_o(aser), .audio_fmt_o(afmt), .audio_width_o(awid));
	optc_host i_optc_host (.sys_clk_i(sys_clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata));

	// ********************************************
	// clock and watchdog
	// ********************************************
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial
	begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		test_done();
	end

	// ********************************************
	// helpers
	// ********************************************
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
	begin
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
	begin
		i_optc_host.rd(a, d);
		chk(48'(d), 48'(exp));
	end
	endtask

	task automatic settle();
	begin
		repeat (3) @(negedge sys_clk);
	end
	endtask

	task automatic test_done();
	begin
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask

	// ********************************************
	// tests
	// ********************************************
	initial
	begin
		rst_n = 1'b0;
		pdi = 1'b0;
		sp = 1'b0;
		fs = 1'b0;
		ls = 3'h0;
		ad = 4'h5;
		lc = 4'ha;
		repeat (3) @(negedge sys_clk);
		rst_n = 1'b1;
		settle();
		chk(48'(pd_o), 48'h1);
		chk(48'(oe), 48'(6'b000100));
		for (i = 0; i < 10; i++)
			rchk(8'h25 + 8'(i), rst_tab[i]);
		rchk(8'h24, 8'h00);
		rchk(8'h30, 8'h00);
		sp = 1'b1;
		settle();
		chk(48'(pd_o), 48'h0);
		chk(48'(oe), 48'(6'b101111));
		for (i = 0; i < 4; i++)
		begin
			i_optc_host.wr(8'h26, 8'h08 | (8'h80 >> i));
			settle();
			chk(48'(oe), 48'(tri_tab[i]));
		end
		i_optc_host.wr(8'h26, 8'h08);
		i_optc_host.wr(8'h25, 8'h73);
		settle();
		chk(48'(oe), 48'(6'b111111));
		i_optc_host.wr(8'h25, 8'h71);
		settle();
		chk(48'(oe), 48'(6'b011111));
		for (i = 0; i < 4; i++)
		begin
			i_optc_host.wr(8'h25, {4'h7, 2'(i), 2'b10});
			settle();
			chk(48'(blue), 48'(i == 1 || i == 2));
			chk(48'(ddr), 48'h1);
		end
		for (i = 0; i < 8; i++)
		begin
			i_optc_host.wr(8'h26, {4'h0, 3'(i), 1'b0});
			pdi = i[2];
			settle();
			chk(48'(pd_o), 48'(!i[1]));
			chk(48'(oe), i[0] ? 48'h0 : 48'(6'b000100));
			pdi = !i[2];
			settle();
			chk(48'(pd_o), 48'h0);
			chk(48'(oe), 48'(6'b101111));
		end
		i_optc_host.wr(8'h26, 8'h09);
		settle();
		chk(48'(pd_o), 48'h1);
		chk(48'(oe), 48'(6'b000100));
		rchk(8'h26, 8'h09);
		i_optc_host.wr(8'h2e, 8'h3c);
		rchk(8'h2e, 8'h3c);
		i_optc_host.wr(8'h26, 8'h08);
		i_optc_host.wr(8'h27, 8'h78);
		settle();
		chk(48'({cp, mc, emb, de}), 48'hf);
		i_optc_host.wr(8'h27, 8'h50);
		settle();
		chk(48'({cp, mc, emb, de}), 48'ha);
		i_optc_host.wr(8'h27, 8'h05);
		sp = 1'b0;
		settle();
		chk(48'(pd_o), 48'h0);
		sp = 1'b1;
		i_optc_host.wr(8'h28, 8'h26);
		i_optc_host.wr(8'h29, 8'h3c);
		i_optc_host.wr(8'h2a, 8'hf7);
		i_optc_host.wr(8'h2b, 8'ha5);
		i_optc_host.wr(8'h2c, 8'h03);
		i_optc_host.wr(8'h2d, 8'h1e);
		settle();
		chk(48'(tim), 48'({3'h0, 6'h18, 10'h104, 12'h500, 12'h2d0}));
		fs = 1'b1;
		@(negedge sys_clk);
		fs = 1'b0;
		settle();
		chk(48'(tim), 48'({3'h5, 6'h09, 10'h23c, 12'h7a5, 12'h31e}));
		rchk(8'h2a, 8'h07);
		rchk(8'h2c, 8'h03);
		chk(48'(aser), 48'h5);
		for (i = 0; i < 4; i++)
		begin
			i_optc_host.wr(8'h2e, {i[0], 2'(i), 5'h10});
			settle();
			chk(48'(aser), i[0] ? 48'ha : 48'h5);
			chk(48'(afmt), 48'(i));
			chk(48'(awid), 48'h10);
		end
		for (i = 0; i < 8; i++)
		begin
			ls = 3'(i);
			i_optc_host.rd(8'h2f, rv);
			chk(48'(rv[6:4]), 48'(i));
		end
		test_done();
	end
endmodule
